// *** inc/ast_pkg.sv ***
package ast_pkg;
   // ==========================================
   // Register map (word aligned byte offsets)
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_TXCFG = 8'h04;
   localparam logic [7:0] ADDR_CMD = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0C;
   localparam logic [7:0] ADDR_STAT0 = 8'h10;
   localparam logic [7:0] ADDR_STAT1 = 8'h14;
   localparam logic [7:0] ADDR_INTEN = 8'h18;
   // ==========================================
   // Mode register fields
   localparam int MODE_CLK_LSB = 0;
   localparam int MODE_PAR_EN = 2;
   localparam int MODE_PAR_EVEN = 3;
   localparam int MODE_STOP2 = 4;
   // Transmitter configuration fields
   localparam int TX_EN = 0;
   localparam int TX_RTS = 1;
   localparam int TX_DTR = 2;
   localparam int TX_AUTO = 3;
   localparam int TX_BREAK = 4;
   localparam int TX_LEN_LSB = 5;
   // Interrupt enable fields
   localparam int IE_TX = 0;
   localparam int IE_EXT = 1;
   // Status bits
   localparam int ST0_TBE = 0;
   localparam int ST0_DCD = 1;
   localparam int ST0_CTS = 2;
   localparam int ST0_SYNC = 3;
   localparam int ST0_EXT_IP = 4;
   localparam int ST0_TX_IP = 5;
   localparam int ST1_ALL_SENT = 0;
   // Commands
   localparam logic [2:0] CMD_RST_EXT = 3'h2;
   localparam logic [2:0] CMD_RST_TXIP = 3'h5;
   // Clock modes and bit-time divisors
   localparam logic [1:0] CLK_X1 = 2'h0;
   localparam logic [1:0] CLK_X16 = 2'h1;
   localparam logic [1:0] CLK_X32 = 2'h2;
   localparam logic [7:0] DIV_X1 = 8'h01;
   localparam logic [7:0] DIV_X16 = 8'h10;
   localparam logic [7:0] DIV_X32 = 8'h20;
   localparam logic [7:0] DIV_X64 = 8'h40;
   // Glitch filter: minimum qualifying pulse width
   localparam int MIN_PULSE_NS = 200;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      AST_IDLE,
      AST_START,
      AST_DATA,
      AST_PARITY,
      AST_STOP,
      AST_TAIL
   } ast_state_e;
endpackage : ast_pkg

// *** core/ast_tx.sv ***
// The implementer's own choices: the address map and the APB register port.
module ast_tx (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic transmit_shift_clock,
   input wire logic cts_n,
   input wire logic dcd_n,
   input wire logic sync_in,
   output logic txd,
   output logic rts_n,
   output logic dtr_n,
   output logic irq_tx,
   output logic irq_ext
);
   // ==========================================
   // Register bus
   logic [7:0] mode_ff;
   logic [7:0] txcfg_ff;
   logic [1:0] inten_ff;
   logic [7:0] buf_ff;
   logic buf_full_ff;
   logic tbe_ff;
   logic txip_ff;
   logic armed_ff;
   logic extip_ff;
   logic [2:0] ext_latch_ff;
   logic all_sent_ff;
   logic rts_pin_ff;
   logic wr;
   logic rd;
   logic wr_data;
   logic wr_cmd;
   logic load;
   logic [31:0] nxt_prdata;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign wr_data = wr && (paddr == ast_pkg::ADDR_DATA);
   assign wr_cmd = wr && (paddr == ast_pkg::ADDR_CMD);
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff <= 8'h00;
         txcfg_ff <= 8'h00;
         inten_ff <= 2'h0;
      end else if (wr) begin
         case (paddr)
            ast_pkg::ADDR_MODE: mode_ff <= pwdata[7:0];
            ast_pkg::ADDR_TXCFG: txcfg_ff <= pwdata[7:0];
            ast_pkg::ADDR_INTEN: inten_ff <= pwdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // Input qualification
   logic [2:0] pins;
   logic [2:0] filt_ff;
   logic [2:0] cand_ff;
   logic [7:0] cnt_ff [3];
   logic [2:0] chg;
   assign pins = {sync_in, cts_n, dcd_n};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cand_ff[gi] <= 1'b1;
               filt_ff[gi] <= 1'b1;
               cnt_ff[gi] <= 8'h00;
            end else if (pins[gi] != cand_ff[gi]) begin
               cand_ff[gi] <= pins[gi];
               cnt_ff[gi] <= 8'h00;
            end else if (cand_ff[gi] != filt_ff[gi]) begin
               if (cnt_ff[gi] >= 8'(ast_pkg::MIN_PULSE_CYC)) begin
                  filt_ff[gi] <= cand_ff[gi];
               end else begin
                  cnt_ff[gi] <= cnt_ff[gi] + 8'h01;
               end
            end
         end
         assign chg[gi] = (cand_ff[gi] != filt_ff[gi]) && (cnt_ff[gi] >= 8'(ast_pkg::MIN_PULSE_CYC));
      end
   endgenerate

   // Latches freeze after an event so software sees the state that caused it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extip_ff <= 1'b0;
         armed_ff <= 1'b1;
         ext_latch_ff <= 3'h7;
      end else if (armed_ff && inten_ff[ast_pkg::IE_EXT] && (chg != 3'h0)) begin
         extip_ff <= 1'b1;
         armed_ff <= 1'b0;
         ext_latch_ff <= filt_ff ^ chg;
      end else if (wr_cmd && pwdata[2:0] == ast_pkg::CMD_RST_EXT) begin
         extip_ff <= 1'b0;
         armed_ff <= 1'b1;
      end else if (armed_ff) begin
         ext_latch_ff <= filt_ff;
      end
   end
   assign irq_ext = extip_ff;

   // ==========================================
   // Shift clock edge detection (sampled as synchronous input)
   logic tsc_ff;
   logic tsc_fall;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tsc_ff <= 1'b1;
      end else begin
         tsc_ff <= transmit_shift_clock;
      end
   end
   assign tsc_fall = tsc_ff && !transmit_shift_clock;

   logic [7:0] divisor;
   always_comb begin
      case (mode_ff[ast_pkg::MODE_CLK_LSB +: 2])
         ast_pkg::CLK_X1: divisor = ast_pkg::DIV_X1;
         ast_pkg::CLK_X16: divisor = ast_pkg::DIV_X16;
         ast_pkg::CLK_X32: divisor = ast_pkg::DIV_X32;
         default: divisor = ast_pkg::DIV_X64;
      endcase
   end

   // ==========================================
   // Transmit state machine
   ast_pkg::ast_state_e state_ff;
   logic [7:0] div_ff;
   logic [7:0] shift_ff;
   logic [3:0] bit_ff;
   logic [3:0] nbits_ff;
   logic par_ff;
   logic stop2_ff;
   logic txd_ff;
   logic bit_end;
   logic go;
   logic [3:0] char_len;
   logic [7:0] char_mask;
   logic [7:0] enc_data;
   logic [2:0] low5;

   assign bit_end = tsc_fall && (div_ff == divisor - 8'h01);
   assign go = txcfg_ff[ast_pkg::TX_EN] && buf_full_ff
      && (!txcfg_ff[ast_pkg::TX_AUTO] || !filt_ff[1]);
   assign char_len = {1'b0, txcfg_ff[ast_pkg::TX_LEN_LSB +: 3]} + 4'h1;
   assign char_mask = 8'(16'h00FF >> (4'h8 - char_len));

   // Short characters: data is masked to the character length, with no marker bits
   always_comb begin
      low5 = 3'h0;
      enc_data = buf_ff & char_mask;
      if (char_len <= 4'h5) begin
         for (int i = 7; i >= 0; i--) begin
            if (!buf_ff[i] && low5 == 3'h0 && i > 0) begin
               low5 = 3'(i);
            end
         end
         enc_data = buf_ff & char_mask;
      end
   end
   // A character may also start from the tail bit time, always on a shift clock fall
   assign load = ((state_ff == ast_pkg::AST_IDLE) || (state_ff == ast_pkg::AST_TAIL)) && go && tsc_fall;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ast_pkg::AST_IDLE;
         div_ff <= 8'h00;
         shift_ff <= 8'h00;
         bit_ff <= 4'h0;
         nbits_ff <= 4'h0;
         par_ff <= 1'b0;
         stop2_ff <= 1'b0;
         txd_ff <= 1'b1;
      end else begin
         if (tsc_fall) begin
            div_ff <= bit_end ? 8'h00 : div_ff + 8'h01;
         end
         case (state_ff)
            ast_pkg::AST_IDLE: begin
               txd_ff <= 1'b1;
               if (load) begin
                  shift_ff <= enc_data;
                  nbits_ff <= char_len;
                  par_ff <= ^enc_data ^ !mode_ff[ast_pkg::MODE_PAR_EVEN];
                  stop2_ff <= mode_ff[ast_pkg::MODE_STOP2];
                  div_ff <= 8'h00;
                  txd_ff <= 1'b0;
                  state_ff <= ast_pkg::AST_START;
               end
            end
            ast_pkg::AST_START: if (bit_end) begin
               txd_ff <= shift_ff[0];
               shift_ff <= shift_ff >> 1;
               bit_ff <= 4'h1;
               state_ff <= ast_pkg::AST_DATA;
            end
            ast_pkg::AST_DATA: if (bit_end) begin
               if (bit_ff < nbits_ff) begin
                  txd_ff <= shift_ff[0];
                  shift_ff <= shift_ff >> 1;
                  bit_ff <= bit_ff + 4'h1;
               end else if (mode_ff[ast_pkg::MODE_PAR_EN]) begin
                  txd_ff <= par_ff;
                  state_ff <= ast_pkg::AST_PARITY;
               end else begin
                  txd_ff <= 1'b1;
                  bit_ff <= 4'h0;
                  state_ff <= ast_pkg::AST_STOP;
               end
            end
            ast_pkg::AST_PARITY: if (bit_end) begin
               txd_ff <= 1'b1;
               bit_ff <= 4'h0;
               state_ff <= ast_pkg::AST_STOP;
            end
            ast_pkg::AST_STOP: if (bit_end) begin
               if (stop2_ff && bit_ff == 4'h0) begin
                  bit_ff <= 4'h1;
               end else if (go) begin
                  // Back-to-back: the start bit follows the last stop bit on the same fall
                  shift_ff <= enc_data;
                  nbits_ff <= char_len;
                  par_ff <= ^enc_data ^ !mode_ff[ast_pkg::MODE_PAR_EVEN];
                  stop2_ff <= mode_ff[ast_pkg::MODE_STOP2];
                  txd_ff <= 1'b0;
                  state_ff <= ast_pkg::AST_START;
               end else begin
                  state_ff <= ast_pkg::AST_TAIL;
               end
            end
            ast_pkg::AST_TAIL: begin
               // One idle bit time for all-sent, unless a late character arrives
               if (load) begin
                  shift_ff <= enc_data;
                  nbits_ff <= char_len;
                  par_ff <= ^enc_data ^ !mode_ff[ast_pkg::MODE_PAR_EVEN];
                  stop2_ff <= mode_ff[ast_pkg::MODE_STOP2];
                  div_ff <= 8'h00;
                  txd_ff <= 1'b0;
                  state_ff <= ast_pkg::AST_START;
               end else if (bit_end) begin
                  state_ff <= ast_pkg::AST_IDLE;
               end
            end
            default: state_ff <= ast_pkg::AST_IDLE;
         endcase
      end
   end

   logic take;
   logic stop_last;
   // Last stop bit ends here; a waiting character is taken on that same fall
   assign stop_last = (state_ff == ast_pkg::AST_STOP) && bit_end && !(stop2_ff && bit_ff == 4'h0);
   assign take = load || (stop_last && go);
   assign txd = txcfg_ff[ast_pkg::TX_BREAK] ? 1'b0 : txd_ff;

   // ==========================================
   // Buffer and status flags (a take wins over a buffer write or command in the same cycle)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_ff <= 8'h00;
         buf_full_ff <= 1'b0;
         tbe_ff <= 1'b1;
         txip_ff <= 1'b0;
      end else begin
         if (wr_data) begin
            buf_ff <= pwdata[7:0];
         end
         if (take) begin
            buf_full_ff <= 1'b0;
            tbe_ff <= 1'b1;
            txip_ff <= inten_ff[ast_pkg::IE_TX];
         end else if (wr_data) begin
            buf_full_ff <= 1'b1;
            tbe_ff <= 1'b0;
            txip_ff <= 1'b0;
         end else if (wr_cmd && pwdata[2:0] == ast_pkg::CMD_RST_TXIP) begin
            txip_ff <= 1'b0;
         end
      end
   end
   // The request line is gated by its enable; the pending bit in status is set only while enabled
   assign irq_tx = txip_ff && inten_ff[ast_pkg::IE_TX];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         all_sent_ff <= 1'b1;
         rts_pin_ff <= 1'b1;
      end else begin
         if (take || buf_full_ff) begin
            all_sent_ff <= 1'b0;
         end else if (state_ff == ast_pkg::AST_TAIL && bit_end) begin
            all_sent_ff <= 1'b1;
         end
         if (txcfg_ff[ast_pkg::TX_RTS]) begin
            rts_pin_ff <= 1'b0;
         end else if (all_sent_ff || (state_ff == ast_pkg::AST_TAIL && bit_end && !buf_full_ff)) begin
            rts_pin_ff <= 1'b1;
         end
      end
   end
   assign rts_n = txcfg_ff[ast_pkg::TX_RTS] ? 1'b0 : rts_pin_ff;
   assign dtr_n = !txcfg_ff[ast_pkg::TX_DTR];

   // ==========================================
   // Read mux
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      case (paddr)
         ast_pkg::ADDR_MODE: nxt_prdata[7:0] = mode_ff;
         ast_pkg::ADDR_TXCFG: nxt_prdata[7:0] = txcfg_ff;
         ast_pkg::ADDR_DATA: nxt_prdata[7:0] = buf_ff;
         ast_pkg::ADDR_INTEN: nxt_prdata[1:0] = inten_ff;
         ast_pkg::ADDR_STAT0: begin
            nxt_prdata[ast_pkg::ST0_TBE] = tbe_ff;
            nxt_prdata[ast_pkg::ST0_SYNC:ast_pkg::ST0_DCD] = ext_latch_ff;
            nxt_prdata[ast_pkg::ST0_EXT_IP] = extip_ff;
            nxt_prdata[ast_pkg::ST0_TX_IP] = txip_ff;
         end
         ast_pkg::ADDR_STAT1: nxt_prdata[ast_pkg::ST1_ALL_SENT] = all_sent_ff;
         default: nxt_prdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= nxt_prdata;
      end
   end
   logic unused_rd;
   assign unused_rd = rd ^ (|low5);
endmodule : ast_tx

// *** bench/ast_tx_assertions.sv ***
module ast_tx_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic cts_n,
   input wire logic dcd_n,
   input wire logic sync_in,
   input wire logic txd,
   input wire logic rts_n,
   input wire logic dtr_n,
   input wire logic irq_tx,
   input wire logic irq_ext
);
   // ==========================================
   // Mirror of software configuration
   logic wr;
   logic [4:0] cfg_ff;
   logic [1:0] ie_ff;
   logic [1:0] age_ff;
   logic [2:0] in_ff;
   logic [5:0] quiet_ff;
   assign wr = psel && penable && pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= 5'h00;
         ie_ff <= 2'h0;
         age_ff <= 2'h0;
      end else if (wr && (paddr == ast_pkg::ADDR_TXCFG || paddr == ast_pkg::ADDR_INTEN)) begin
         if (paddr == ast_pkg::ADDR_TXCFG) cfg_ff <= pwdata[4:0];
         else ie_ff <= pwdata[1:0];
         age_ff <= 2'h0;
      end else if (age_ff != 2'h3) begin
         age_ff <= age_ff + 2'h1;
      end
   end
   // Cycles since any modem input last moved, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_ff <= 3'h6;
         quiet_ff <= 6'h00;
      end else begin
         in_ff <= {cts_n, dcd_n, sync_in};
         quiet_ff <= (in_ff != {cts_n, dcd_n, sync_in}) ? 6'h00 : quiet_ff + {5'h00, quiet_ff != 6'h3F};
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_dtr_follows: assert property (age_ff == 2'h3 |-> dtr_n == !cfg_ff[ast_pkg::TX_DTR])
      else $error("dtr_n does not follow its bit");
   chk_rts_set_low: assert property (age_ff == 2'h3 && cfg_ff[ast_pkg::TX_RTS] |-> !rts_n)
      else $error("rts_n high while its bit is set");
   chk_break_low: assert property (age_ff == 2'h3 && cfg_ff[ast_pkg::TX_BREAK] |-> !txd)
      else $error("txd not spacing during break");
   chk_idle_no_en: assert property (age_ff == 2'h3 && cfg_ff[4:0] == 5'h00 |-> txd)
      else $error("txd left marking without enable");
   chk_reset_idle: assert property ($rose(presetn) |-> txd [*2])
      else $error("txd not marking after reset");
   chk_tx_gated: assert property (age_ff == 2'h3 && !ie_ff[ast_pkg::IE_TX] |-> !irq_tx)
      else $error("irq_tx raised while disabled");
   chk_txip_cmd: assert property (wr && paddr == ast_pkg::ADDR_CMD && pwdata[2:0] == ast_pkg::CMD_RST_TXIP
         |=> !irq_tx)
      else $error("irq_tx survived command 5");
   chk_txip_write: assert property (wr && paddr == ast_pkg::ADDR_DATA |=> !irq_tx)
      else $error("irq_tx survived a buffer write");
   chk_ext_rearm: assert property (wr && paddr == ast_pkg::ADDR_CMD && pwdata[2:0] == ast_pkg::CMD_RST_EXT
         && quiet_ff > 6'h28 |=> !irq_ext)
      else $error("irq_ext survived command 2");
   chk_glitch_filt: assert property ($rose(irq_ext) |-> quiet_ff >= 6'h11)
      else $error("irq_ext raised by a short pulse");
   cover property ($rose(irq_tx));
   cover property ($rose(irq_ext));
   cover property ($fell(txd) ##1 !txd);
endmodule : ast_tx_checker

bind ast_tx ast_tx_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cts_n(cts_n), .dcd_n(dcd_n), .sync_in(sync_in),
   .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n), .irq_tx(irq_tx), .irq_ext(irq_ext));

// *** bench/ast_remote.sv ***
module ast_remote (
   input wire logic tx_line,
   input wire logic [7:0] div,
   input wire logic [3:0] nbits,
   input wire logic cts_req,
   input wire logic dcd_req,
   input wire logic sync_req,
   output logic shift_clk,
   output logic cts_n,
   output logic dcd_n,
   output logic sync_in,
   output logic [11:0] frame,
   output int frames
);
   timeunit 1ns;
   timeprecision 100ps;
   logic busy;
   logic [11:0] acc;
   int cnt;
   int half;
   int k;
   assign cts_n = !cts_req;
   assign dcd_n = !dcd_req;
   assign sync_in = sync_req;
   // A rate generator runs free, so the shift clock does too
   initial begin
      shift_clk = 1'b0;
      busy = 1'b0;
      frame = 12'h000;
      frames = 0;
      #3;
      forever #80 shift_clk = ~shift_clk;
   end
   // Sample mid-bit on rising edges; bits after the start bit land LSB first
   always @(posedge shift_clk) begin
      half = int'(div) / 2;
      if (!busy && tx_line === 1'b0) begin
         busy = 1'b1;
         cnt = 0;
         acc = 12'h000;
      end else if (busy) begin
         cnt++;
      end
      k = (cnt - half) / int'(div);
      if (busy && cnt >= half && (cnt - half) % int'(div) == 0) begin
         if (k > 0) acc[k - 1] = tx_line;
         if (k == int'(nbits)) begin
            frame = acc;
            frames++;
            busy = 1'b0;
         end
      end
   end
endmodule : ast_remote

// *** bench/testbench.sv ***
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sclk, cts_n, dcd_n, sync_in;
   logic txd, rts_n, dtr_n, irq_tx, irq_ext, cts_req, dcd_req, sync_req;
   logic [7:0] paddr, div;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] nbits;
   logic [11:0] frame;
   int frames, n_fail, n_checks, f0;
   logic [4:0] modes [5] = '{5'h0C, 5'h15, 5'h02, 5'h0F, 5'h10};
   int lens [5] = '{8, 7, 6, 1, 5};
   logic [7:0] chars [5] = '{8'hA5, 8'hFF, 8'hC3, 8'h03, 8'hE9};
   ast_tx dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .transmit_shift_clock(sclk), .cts_n(cts_n), .dcd_n(dcd_n), .sync_in(sync_in), .txd(txd),
      .rts_n(rts_n), .dtr_n(dtr_n), .irq_tx(irq_tx), .irq_ext(irq_ext));
   ast_remote far_u (.tx_line(txd), .div(div), .nbits(nbits), .cts_req(cts_req), .dcd_req(dcd_req),
      .sync_req(sync_req), .shift_clk(sclk), .cts_n(cts_n), .dcd_n(dcd_n), .sync_in(sync_in),
      .frame(frame), .frames(frames));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ==========================================
   // Bus and helper tasks
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic wait_frame(input int c);
      while (frames == c) begin
         @(posedge pclk);
      end
   endtask : wait_frame
   function automatic logic [11:0] exp_frame(input logic [7:0] d, input int len, input logic [4:0] m);
      logic [11:0] f;
      logic p;
      f = 12'h000;
      p = !m[ast_pkg::MODE_PAR_EVEN];
      for (int i = 0; i < len; i++) begin
         f[i] = d[i];
         p ^= d[i];
      end
      if (m[ast_pkg::MODE_PAR_EN]) begin
         f[len] = p;
         len++;
      end
      f[len] = 1'b1;
      f[len + 1] = m[ast_pkg::MODE_STOP2];
      return f;
   endfunction : exp_frame
   task automatic send(input logic [4:0] m, input int len, input logic [7:0] d);
      apb(ast_pkg::ADDR_MODE, 1'b1, {27'h0, m});
      apb(ast_pkg::ADDR_TXCFG, 1'b1, {24'h0, 3'(len - 1), 5'h07});
      div <= (m[1:0] == 2'h0) ? 8'h01 : 8'h08 << m[1:0];
      nbits <= 4'(len + int'(m[2]) + 1 + int'(m[4]));
      f0 = frames;
      apb(ast_pkg::ADDR_DATA, 1'b1, {24'h0, d});
      apb(ast_pkg::ADDR_STAT1, 1'b0, 32'h0);
      `CHK("all_sent busy", 1'b0, q[ast_pkg::ST1_ALL_SENT])
      wait_frame(f0);
      `CHK("frame", exp_frame(d, len, m), frame)
      `CHK("rts_dtr", 2'b00, {rts_n, dtr_n})
      `CHK("irq_tx", 1'b1, irq_tx)
      apb(ast_pkg::ADDR_STAT0, 1'b0, 32'h0);
      `CHK("tbe", 1'b1, q[ast_pkg::ST0_TBE])
      cyc(48 * int'(div));
      apb(ast_pkg::ADDR_STAT1, 1'b0, 32'h0);
      `CHK("all_sent done", 1'b1, q[ast_pkg::ST1_ALL_SENT])
   endtask : send
   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      #900us;
      n_fail++;
      finish_test();
   end
   // ==========================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn, dcd_req, sync_req} = '0;
      {div, nbits, cts_req, n_fail, n_checks} = {8'h01, 4'hA, 1'b1, 32'd0, 32'd0};
      cyc(12);
      presetn <= 1'b1;
      cyc(2);
      `CHK("reset pins", 3'b111, {txd, rts_n, dtr_n})
      apb(ast_pkg::ADDR_INTEN, 1'b1, 32'h3);
      for (int i = 0; i < 5; i++) send(modes[i], lens[i], chars[i]);
      // Back-to-back characters with the buffer refilled mid-flight
      send(5'h0C, 8, 8'hA5);
      f0 = frames;
      apb(ast_pkg::ADDR_DATA, 1'b1, 32'h5A);
      cyc(40);
      apb(ast_pkg::ADDR_DATA, 1'b1, 32'hC6);
      `CHK("irq_tx refill", 1'b0, irq_tx)
      apb(ast_pkg::ADDR_STAT0, 1'b0, 32'h0);
      `CHK("tbe refill", 1'b0, q[ast_pkg::ST0_TBE])
      wait_frame(f0);
      `CHK("first of pair", exp_frame(8'h5A, 8, 5'h0C), frame)
      cyc(40);
      apb(ast_pkg::ADDR_CMD, 1'b1, 32'h5);
      `CHK("irq_tx cmd", 1'b0, irq_tx)
      apb(ast_pkg::ADDR_TXCFG, 1'b1, 32'hE5);
      `CHK("rts held", 1'b0, rts_n)
      wait_frame(f0 + 1);
      `CHK("second frame", exp_frame(8'hC6, 8, 5'h0C), frame)
      cyc(60);
      `CHK("rts released", 2'b10, {rts_n, irq_tx})
      // Auto-enable waits for clear-to-send
      apb(ast_pkg::ADDR_CMD, 1'b1, 32'h2);
      cts_req <= 1'b0;
      cyc(40);
      `CHK("cts edge irq", 1'b1, irq_ext)
      apb(ast_pkg::ADDR_CMD, 1'b1, 32'h2);
      `CHK("ext rearm", 1'b0, irq_ext)
      apb(ast_pkg::ADDR_TXCFG, 1'b1, 32'hEF);
      f0 = frames;
      apb(ast_pkg::ADDR_DATA, 1'b1, 32'h3C);
      cyc(200);
      `CHK("held by cts", {1'b1, f0}, {txd, frames})
      cts_req <= 1'b1;
      cyc(40);
      `CHK("cts edge irq2", 1'b1, irq_ext)
      wait_frame(f0);
      `CHK("auto frame", exp_frame(8'h3C, 8, 5'h0C), frame)
      apb(ast_pkg::ADDR_CMD, 1'b1, 32'h2);
      // Short glitch, then a lasting change
      dcd_req <= 1'b1;
      cyc(5);
      dcd_req <= 1'b0;
      cyc(50);
      `CHK("glitch", 1'b0, irq_ext)
      dcd_req <= 1'b1;
      cyc(40);
      `CHK("dcd change", 1'b1, irq_ext)
      apb(ast_pkg::ADDR_CMD, 1'b1, 32'h2);
      apb(ast_pkg::ADDR_INTEN, 1'b1, 32'h0);
      `CHK("irq_tx masked", 1'b0, irq_tx)
      sync_req <= 1'b1;
      cyc(40);
      `CHK("ext disabled", 1'b0, irq_ext)
      // Break with the transmitter disabled, then release
      apb(ast_pkg::ADDR_TXCFG, 1'b1, 32'h10);
      cyc(100);
      `CHK("break", 1'b0, txd)
      apb(ast_pkg::ADDR_TXCFG, 1'b1, 32'h0);
      cyc(3);
      `CHK("idle after break", 1'b1, txd)
      apb(8'h1C, 1'b1, 32'hFFFFFFFF);
      apb(8'h1C, 1'b0, 32'h0);
      `CHK("unmapped", 32'h0, q)
      finish_test();
   end
endmodule : testbench
